// ---- shared/gpp_pkg.sv ----
package gpp_pkg;

  // ------------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------------
  localparam int unsigned GPP_PINS   = 6;
  localparam int unsigned GPP_ADDR_W = 12;
  localparam int unsigned GPP_DATA_W = 32;
  localparam int unsigned GPP_CNT_W  = 4;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [GPP_ADDR_W-1:0] GPP_OFF_GIRQ_STATUS = 12'h058;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFF_GIRQ_ENABLE = 12'h05c;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFF_PIN_CONFIG  = 12'h1e0;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFF_PIN_DATADIR = 12'h1e4;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFF_PIN_IRQ     = 12'h1e8;

  // ------------------------------------------------------------------
  // Field positions (low bit of each six-bit field, and the one global bit)
  // ------------------------------------------------------------------
  localparam int unsigned GPP_POL_LSB  = 16;
  localparam int unsigned GPP_DRV_LSB  = 0;
  localparam int unsigned GPP_DIR_LSB  = 16;
  localparam int unsigned GPP_DAT_LSB  = 0;
  localparam int unsigned GPP_EN_LSB   = 16;
  localparam int unsigned GPP_ST_LSB   = 0;
  localparam int unsigned GPP_GIRQ_BIT = 12;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [GPP_PINS-1:0]   GPP_RST_FIELD = 6'h00;
  localparam logic                  GPP_RST_BIT   = 1'b0;
  localparam logic [GPP_DATA_W-1:0] GPP_RST_WORD  = 32'h0000_0000;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int unsigned GPP_CLK_PERIOD_PS = 4000;
  localparam int unsigned GPP_TRIG_MIN_NS   = 40;
  // Least time, rounded up to whole cycles
  localparam int unsigned GPP_TRIG_CYCLES =
    (GPP_TRIG_MIN_NS * 1000 + GPP_CLK_PERIOD_PS - 1) / GPP_CLK_PERIOD_PS;
  // Qualify on half the guaranteed width, so a legal level is never missed
  localparam int unsigned GPP_QUAL_CYCLES = GPP_TRIG_CYCLES / 2;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef logic [GPP_PINS-1:0]  gpp_pins_t;
  typedef logic [GPP_CNT_W-1:0] gpp_cnt_t;

  typedef struct packed {
    gpp_pins_t                 level_trigger_polarity;
    gpp_pins_t                 output_driver_type;
    gpp_pins_t                 pin_direction;
    gpp_pins_t                 pin_data_value;
    gpp_pins_t                 irq_flag;
    gpp_pins_t                 irq_enable;
    logic                      global_pin_enable;
    gpp_cnt_t [GPP_PINS-1:0]   match_cnt;
    logic [GPP_DATA_W-1:0]     rdata;
    gpp_pins_t                 pad_out;
    gpp_pins_t                 pad_oe;
    logic                      pin_event;
    logic                      irq;
  } gpp_state_s;

endpackage : gpp_pkg

// ---- hw/gpp_sync.sv ----
`timescale 1ns/1ps

module gpp_sync
  import gpp_pkg::*;
#(
  parameter int unsigned W = GPP_PINS
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output      logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } gpp_sync_s;

  gpp_sync_s state_q;
  gpp_sync_s state_d;

  // Stage one feeds only stage two, never any logic
  always_comb begin
    state_d        = state_q;
    state_d.stage1 = async_in;
    state_d.stage2 = state_q.stage1;
  end

  // Two flops per pin, cleared by reset
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.stage2;

endmodule : gpp_sync

// ---- hw/gpp_port.sv ----
// Our own choice: strobed register access.
`timescale 1ns/1ps

// Contract
// - Flag sets while pin level matches polarity
// - Driver bit 0 open-drain, 1 push-pull
// - Open-drain: data 0 drives low, 1 floats
// - Direction bit 0 input, 1 output
// - Output pin shows last written data bit
// - Input pin reads back its sampled level
// - Output pin reads back written data
// - Writing one clears flag, zero keeps
// - Flags set regardless of enable bits
// - Enable bit makes flag an event source
// - Event is OR of enabled flags, forwarded
// - Interrupt needs global pin enable too
// - Levels held over 40 ns are recognised
// - Event at bit 12 of global registers
module gpp_port
  import gpp_pkg::*;
#(
  parameter int unsigned QUAL_CYCLES = GPP_QUAL_CYCLES
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic [GPP_ADDR_W-1:0] addr,
  input  wire logic [GPP_DATA_W-1:0] wdata,
  input  wire logic                  we,
  input  wire logic                  re,
  output      logic [GPP_DATA_W-1:0] rdata,
  input  wire logic [GPP_PINS-1:0]   pin_in,
  output      logic [GPP_PINS-1:0]   pin_out,
  output      logic [GPP_PINS-1:0]   pin_oe,
  output      logic                  pin_event,
  output      logic                  irq
);

  // ------------------------------------------------------------------
  // Constants and state
  // ------------------------------------------------------------------
  localparam gpp_cnt_t CNT_TOP  = GPP_CNT_W'(QUAL_CYCLES);
  localparam gpp_cnt_t CNT_LAST = GPP_CNT_W'(QUAL_CYCLES - 1);
  localparam gpp_cnt_t CNT_ONE  = 4'h1;

  gpp_state_s state_q;
  gpp_state_s state_d;

  gpp_pins_t                 pin_sync;
  gpp_pins_t                 level_match;
  gpp_pins_t                 trig;
  gpp_cnt_t [GPP_PINS-1:0]   cnt_nx;
  gpp_pins_t                 clr_v;
  gpp_pins_t                 data_view;
  logic [GPP_DATA_W-1:0]     rd_word;
  logic                      wr_cfg;
  logic                      wr_dat;
  logic                      wr_sts;
  logic                      wr_gen;

  // One clock domain, so every assertion shares this clock and reset
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // ------------------------------------------------------------------
  // Pin input synchroniser
  // ------------------------------------------------------------------
  // Pins are asynchronous, so nothing reads them before two flops
  gpp_sync #(
    .W (GPP_PINS)
  ) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // ------------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------------
  // Full address compare, so aliases never hit a register
  assign wr_cfg = we && (addr == GPP_OFF_PIN_CONFIG);
  assign wr_dat = we && (addr == GPP_OFF_PIN_DATADIR);
  assign wr_sts = we && (addr == GPP_OFF_PIN_IRQ);
  assign wr_gen = we && (addr == GPP_OFF_GIRQ_ENABLE);

  // Ones written to the status field acknowledge those flags
  assign clr_v = wr_sts ? wdata[GPP_ST_LSB +: GPP_PINS] : GPP_RST_FIELD;

  // ------------------------------------------------------------------
  // Per-pin level qualifier
  // ------------------------------------------------------------------
  // A short run of matching samples filters single-sample glitches;
  // the run is well under the guaranteed width of a legal level.
  for (genvar i = 0; i < GPP_PINS; i++) begin : g_pin
    // Polarity 0 matches low, 1 matches high
    assign level_match[i] =
      ~(pin_sync[i] ^ state_q.level_trigger_polarity[i]);
    assign cnt_nx[i] = !level_match[i] ? '0 :
                       (state_q.match_cnt[i] == CNT_TOP) ? CNT_TOP :
                       state_q.match_cnt[i] + CNT_ONE;
    // Trigger on the qualifying sample and as long as the level stays
    assign trig[i] = level_match[i] &&
                     (state_q.match_cnt[i] >= CNT_LAST);

    // A level of eight samples always leaves the flag set
    lvl_recog_a: assert property (
      level_match[i] [*8] |=> state_q.irq_flag[i])
      else $error("qualified pin level did not set its flag");
  end

  // ------------------------------------------------------------------
  // Read view of the data field
  // ------------------------------------------------------------------
  // Outputs read the stored bit, inputs the sampled pin
  assign data_view = (state_q.pin_direction & state_q.pin_data_value) |
                     (~state_q.pin_direction & pin_sync);

  // ------------------------------------------------------------------
  // Read multiplexer
  // ------------------------------------------------------------------
  // Unmapped offsets and reserved bits answer zero
  always_comb begin
    rd_word = GPP_RST_WORD;
    case (addr)
      GPP_OFF_PIN_CONFIG: begin
        rd_word[GPP_POL_LSB +: GPP_PINS] = state_q.level_trigger_polarity;
        rd_word[GPP_DRV_LSB +: GPP_PINS] = state_q.output_driver_type;
      end
      GPP_OFF_PIN_DATADIR: begin
        rd_word[GPP_DIR_LSB +: GPP_PINS] = state_q.pin_direction;
        rd_word[GPP_DAT_LSB +: GPP_PINS] = data_view;
      end
      GPP_OFF_PIN_IRQ: begin
        rd_word[GPP_EN_LSB +: GPP_PINS] = state_q.irq_enable;
        rd_word[GPP_ST_LSB +: GPP_PINS] = state_q.irq_flag;
      end
      GPP_OFF_GIRQ_STATUS: begin
        rd_word[GPP_GIRQ_BIT] = state_q.pin_event;
      end
      GPP_OFF_GIRQ_ENABLE: begin
        rd_word[GPP_GIRQ_BIT] = state_q.global_pin_enable;
      end
      default: begin
        rd_word = GPP_RST_WORD;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    state_d = state_q;

    // Configuration: only the defined fields are stored
    if (wr_cfg) begin
      state_d.level_trigger_polarity = wdata[GPP_POL_LSB +: GPP_PINS];
      state_d.output_driver_type     = wdata[GPP_DRV_LSB +: GPP_PINS];
    end

    // Data is stored on every write, whatever the direction
    if (wr_dat) begin
      state_d.pin_direction  = wdata[GPP_DIR_LSB +: GPP_PINS];
      state_d.pin_data_value = wdata[GPP_DAT_LSB +: GPP_PINS];
    end

    if (wr_sts) begin
      state_d.irq_enable = wdata[GPP_EN_LSB +: GPP_PINS];
    end

    // Status write to the global status word is ignored
    if (wr_gen) begin
      state_d.global_pin_enable = wdata[GPP_GIRQ_BIT];
    end

    // Set beats clear, and enables play no part in setting
    state_d.irq_flag  = (state_q.irq_flag & ~clr_v) | trig;
    state_d.match_cnt = cnt_nx;

    // Open-drain pulls low only; push-pull drives both levels
    state_d.pad_oe  = state_q.pin_direction &
                      (state_q.output_driver_type |
                       ~state_q.pin_data_value);
    state_d.pad_out = state_q.pin_direction &
                      state_q.output_driver_type &
                      state_q.pin_data_value;

    // Combined event, then gated by the global enable
    state_d.pin_event = |(state_q.irq_flag & state_q.irq_enable);
    state_d.irq       = |(state_q.irq_flag & state_q.irq_enable) &
                        state_q.global_pin_enable;

    // Read data stand for one cycle only, zero otherwise
    state_d.rdata = re ? rd_word : GPP_RST_WORD;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  // Every field, including pads and read data, clears on reset
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Ports come straight off the state register
  assign rdata     = state_q.rdata;
  assign pin_out   = state_q.pad_out;
  assign pin_oe    = state_q.pad_oe;
  assign pin_event = state_q.pin_event;
  assign irq       = state_q.irq;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  // A trigger always leaves its flag set, acknowledged or not
  flag_set_a: assert property (
    (trig != '0) |=> ((state_q.irq_flag & $past(trig)) == $past(trig)))
    else $error("triggered flag not set");

  // Written ones clear flags that saw no trigger
  flag_clear_a: assert property (
    wr_sts |=> ((state_q.irq_flag & $past(clr_v & ~trig)) == '0))
    else $error("acknowledged flag not cleared");

  // Without a status write no flag ever drops
  flag_hold_a: assert property (
    !wr_sts |=> ((state_q.irq_flag & $past(state_q.irq_flag)) ==
                 $past(state_q.irq_flag)))
    else $error("flag dropped without acknowledge");

  // Enable follows direction and driver type one cycle later
  pad_enable_a: assert property (
    1'b1 |=> (pin_oe == $past(state_q.pin_direction &
                              (state_q.output_driver_type |
                               ~state_q.pin_data_value))))
    else $error("pad enable wrong for direction or driver");

  // Open-drain and input pins never drive a high level
  od_low_only_a: assert property (
    1'b1 |=> ((pin_out & ~$past(state_q.output_driver_type &
                                state_q.pin_direction)) == '0))
    else $error("open-drain pin driven high");

  // Push-pull outputs carry the written data
  pp_value_a: assert property (
    1'b1 |=> ((pin_out ^ $past(state_q.pin_data_value)) &
              $past(state_q.pin_direction &
                    state_q.output_driver_type)) == '0)
    else $error("push-pull pin differs from written data");

  // Data readback mixes stored bits and sampled pins
  data_read_a: assert property (
    (re && (addr == GPP_OFF_PIN_DATADIR)) |=>
      (rdata[GPP_DAT_LSB +: GPP_PINS] == $past(data_view)))
    else $error("data readback wrong");

  // Reserved ranges of the port registers read zero
  rsvd_zero_a: assert property (
    (re && ((addr == GPP_OFF_PIN_CONFIG) ||
            (addr == GPP_OFF_PIN_DATADIR) ||
            (addr == GPP_OFF_PIN_IRQ))) |=>
      ((rdata[31:22] == '0) && (rdata[15:6] == '0)))
    else $error("reserved bits read nonzero");

  // Event is the OR of enabled flags
  event_or_a: assert property (
    1'b1 |=> (pin_event == |$past(state_q.irq_flag & state_q.irq_enable)))
    else $error("combined event wrong");

  // Interrupt never rises without the global enable
  irq_gate_a: assert property (
    irq |-> (pin_event && $past(state_q.global_pin_enable)))
    else $error("interrupt without global enable");

  // Global status bit reads the combined event
  gstat_read_a: assert property (
    (re && (addr == GPP_OFF_GIRQ_STATUS)) |=>
      (rdata[GPP_GIRQ_BIT] == $past(pin_event)))
    else $error("global status bit wrong");

  // Read data vanish the cycle after a non-read
  rdata_idle_a: assert property (
    !re |=> (rdata == '0))
    else $error("read data outside answer cycle");

  // Push-pull outputs always drive their pad
  pp_drive_a: assert property (
    1'b1 |=> ((~pin_oe & $past(state_q.pin_direction &
                               state_q.output_driver_type)) == '0))
    else $error("push-pull output not driven");

  // Open-drain with data set leaves the pad floating
  od_float_a: assert property (
    1'b1 |=> ((pin_oe & $past(~state_q.output_driver_type &
                              state_q.pin_data_value)) == '0))
    else $error("open-drain pin driven while data set");

  // Open-drain output with data clear pulls the pad low
  od_pull_a: assert property (
    1'b1 |=> (((~pin_oe | pin_out) &
               $past(state_q.pin_direction &
                     ~state_q.output_driver_type &
                     ~state_q.pin_data_value)) == '0))
    else $error("open-drain pin not pulled low");

  // Input pins are never driven, whatever the driver type
  input_float_a: assert property (
    1'b1 |=> ((pin_oe & ~$past(state_q.pin_direction)) == '0))
    else $error("input pin driven");

  // A flag only rises after its pin level matched
  flag_rise_a: assert property (
    1'b1 |=> ((state_q.irq_flag & ~$past(state_q.irq_flag) &
               ~$past(level_match)) == '0))
    else $error("flag rose without matching level");

  // An enabled flag raises the event in the next cycle
  event_raise_a: assert property (
    ((state_q.irq_flag & state_q.irq_enable) != '0) |=> pin_event)
    else $error("enabled flag gave no event");

  // With no enabled flag neither event nor interrupt stands
  event_quiet_a: assert property (
    ((state_q.irq_flag & state_q.irq_enable) == '0) |=> (!pin_event && !irq))
    else $error("event without enabled flag");

  // Interrupt is exactly the event gated by the global enable
  irq_follow_a: assert property (
    1'b1 |=> (irq == (pin_event && $past(state_q.global_pin_enable))))
    else $error("interrupt differs from gated event");

  // Global enable reads back at its bit, zero elsewhere
  gen_read_a: assert property (
    (re && (addr == GPP_OFF_GIRQ_ENABLE)) |=>
      (rdata == {19'h0, $past(state_q.global_pin_enable), 12'h000}))
    else $error("global enable readback wrong");

  // Direction field reads back the stored bits
  dir_read_a: assert property (
    (re && (addr == GPP_OFF_PIN_DATADIR)) |=>
      (rdata[GPP_DIR_LSB +: GPP_PINS] == $past(state_q.pin_direction)))
    else $error("direction readback wrong");

  // Outputs leave reset cleared, before any strobe lands
  reset_clear_a: assert property (
    $fell(rst) |-> ((rdata == '0) && (pin_oe == '0) && (pin_out == '0) &&
                    !pin_event && !irq))
    else $error("outputs not cleared by reset");

endmodule : gpp_port

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps

module tb_top
  import gpp_pkg::*;
;
  // ------------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------------
  logic                  clock       = 1'b0;
  logic                  rst         = 1'b1;
  logic [GPP_ADDR_W-1:0] addr        = 12'h000;
  logic [GPP_DATA_W-1:0] wdata       = 32'h0000_0000;
  logic                  we          = 1'b0;
  logic                  re          = 1'b0;
  // Pads idle high so low-polarity detection stays quiet after reset
  logic [GPP_PINS-1:0]   pin_in      = 6'h3f;
  logic [GPP_DATA_W-1:0] rdata;
  logic [GPP_PINS-1:0]   pin_out;
  logic [GPP_PINS-1:0]   pin_oe;
  logic                  pin_event;
  logic                  irq;
  int                    mismatches  = 0;
  int                    total_checks = 0;
  int                    cycles      = 0;

  // Four ns period
  always #2 clock = ~clock;

  gpp_port gpp_port_i (
    .clock     (clock),
    .rst       (rst),
    .addr      (addr),
    .wdata     (wdata),
    .we        (we),
    .re        (re),
    .rdata     (rdata),
    .pin_in    (pin_in),
    .pin_out   (pin_out),
    .pin_oe    (pin_oe),
    .pin_event (pin_event),
    .irq       (irq)
  );

  // ------------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // Hang guard: the whole sequence needs about 150 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      results();
    end
  end

  // ------------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    we    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    we    <= 1'b0;
  endtask : wr

  // Read data stands for one cycle only, then must fall back to zero
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clock);
    re   <= 1'b1;
    addr <= a;
    @(posedge clock);
    re   <= 1'b0;
    #1;
    chk(rdata, exp);
    @(posedge clock);
    #1;
    chk(rdata, 32'h0000_0000);
  endtask : rd

  // Pads lag the registers by one flop, so allow a spare edge
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle

  // Pads change on a rising edge, like every other input
  task automatic pad(input logic [GPP_PINS-1:0] v);
    @(posedge clock);
    pin_in <= v;
  endtask : pad

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    // Registers and pads clear; input bits show the idle-high pads
    rd(GPP_OFF_PIN_CONFIG, 32'h0000_0000);
    rd(GPP_OFF_PIN_DATADIR, 32'h0000_003f);
    rd(GPP_OFF_PIN_IRQ, 32'h0000_0000);
    rd(GPP_OFF_GIRQ_ENABLE, 32'h0000_0000);
    chk({24'h00_0000, pin_oe, pin_event, irq}, 32'h0000_0000);
    // Reserved bits drop, unmapped and read-only places stay zero
    wr(GPP_OFF_PIN_CONFIG, 32'hffff_ffff);
    rd(GPP_OFF_PIN_CONFIG, 32'h003f_003f);
    wr(12'h100, 32'hffff_ffff);
    rd(12'h100, 32'h0000_0000);
    wr(GPP_OFF_GIRQ_STATUS, 32'hffff_ffff);
    rd(GPP_OFF_GIRQ_STATUS, 32'h0000_0000);
    // Mixed directions and driver types: low polarity on all pins
    wr(GPP_OFF_PIN_CONFIG, 32'h0000_0033);
    pin_in <= 6'h35;
    wr(GPP_OFF_PIN_DATADIR, 32'h003c_002a);
    settle(3);
    chk({26'h0, pin_oe}, 32'h0000_0034);
    chk({26'h0, pin_out}, 32'h0000_0020);
    // Output bits read the written value, input bits the pad
    rd(GPP_OFF_PIN_DATADIR, 32'h003c_0029);
    // Pads 1 and 3 sit low (pad 3 is an output); clear all six flags set so far
    pad(6'h3f);
    settle(12);
    wr(GPP_OFF_PIN_IRQ, 32'h0000_003f);
    rd(GPP_OFF_PIN_IRQ, 32'h0000_0000);
    // Switch every pin back to input and show the pad state
    wr(GPP_OFF_PIN_DATADIR, 32'h0000_002a);
    settle(3);
    chk({26'h0, pin_oe}, 32'h0000_0000);
    rd(GPP_OFF_PIN_DATADIR, 32'h0000_003f);
    // A 44 ns low pulse on pad 2 latches its flag with no enable
    pad(6'h3b);
    settle(10);
    pad(6'h3f);
    settle(12);
    rd(GPP_OFF_PIN_IRQ, 32'h0000_0004);
    chk({31'h0, pin_event}, 32'h0000_0000);
    // Per-pin enable raises the event, global enable gates the interrupt
    wr(GPP_OFF_PIN_IRQ, 32'h0004_0000);
    settle(3);
    chk({30'h0, pin_event, irq}, 32'h0000_0002);
    rd(GPP_OFF_GIRQ_STATUS, 32'h0000_1000);
    wr(GPP_OFF_GIRQ_ENABLE, 32'hffff_ffff);
    rd(GPP_OFF_GIRQ_ENABLE, 32'h0000_1000);
    settle(3);
    chk({30'h0, pin_event, irq}, 32'h0000_0003);
    // Writing zero keeps the flag, writing one clears it
    rd(GPP_OFF_PIN_IRQ, 32'h0004_0004);
    wr(GPP_OFF_PIN_IRQ, 32'h0004_0004);
    rd(GPP_OFF_PIN_IRQ, 32'h0004_0000);
    settle(3);
    chk({30'h0, pin_event, irq}, 32'h0000_0000);
    // High polarity on pad 5 flags while the pad sits high
    wr(GPP_OFF_PIN_CONFIG, 32'h0020_0033);
    settle(12);
    rd(GPP_OFF_PIN_IRQ, 32'h0004_0020);
    chk({31'h0, pin_event}, 32'h0000_0000);
    wr(GPP_OFF_PIN_IRQ, 32'h0020_0000);
    settle(3);
    chk({30'h0, pin_event, irq}, 32'h0000_0003);
    // Reset mid-run clears flags, enables and pads again
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    rd(GPP_OFF_PIN_IRQ, 32'h0000_0000);
    rd(GPP_OFF_PIN_CONFIG, 32'h0000_0000);
    rd(GPP_OFF_GIRQ_ENABLE, 32'h0000_0000);
    chk({24'h00_0000, pin_oe, pin_event, irq}, 32'h0000_0000);
    results();
  end

endmodule : tb_top
